// file: pri_rdi_consts.svh
// Purpose: Offsets, field positions, reset values and codes for the path
//          remote-defect indication inserter.
// Assumes: An 8-bit register port with a 16-bit byte address.
// Notes:   Definitions only. This header is included by its bare name.
`ifndef PRI_RDI_CONSTS_SVH
`define PRI_RDI_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define PRI_ADDR_PATH_CTRL   16'h1983
`define PRI_ADDR_LCD_PLM     16'h19C9
`define PRI_ADDR_TIM_UNEQ    16'h19CA
`define PRI_ADDR_LOP_AIS     16'h19CB

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define PRI_SRC_HI           4
`define PRI_SRC_LO           3
`define PRI_HI_CODE_HI       7
`define PRI_HI_CODE_LO       5
`define PRI_HI_EN_BIT        4
`define PRI_LO_CODE_HI       3
`define PRI_LO_CODE_LO       1
`define PRI_LO_EN_BIT        0
`define PRI_G1_FIELD_HI      3
`define PRI_G1_FIELD_LO      1

// ---------------------------------------------------------------------------
// Reset values and fixed codes
// ---------------------------------------------------------------------------
`define PRI_RST_CTRL_BYTE    8'h00
`define PRI_RST_SRC          2'b00
`define PRI_SRC_AUTO         2'b00
`define PRI_CODE_NONE        3'h0
`define PRI_RDATA_UNMAPPED   8'h00

`endif

// file: pri_pkg.sv
// Purpose: Shared types for the path remote-defect indication inserter.
// Assumes: Constants live in pri_rdi_consts.svh.
// Notes:   Defect index order doubles as priority order, highest wins.
package pri_pkg;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef logic [2:0] pri_code_t;   // One 3-bit indication code.
  typedef logic [7:0] pri_byte_t;   // One register or stream byte.

  // Defect slots; a larger index is the more severe defect.
  typedef enum int {
    PRI_DEF_LABEL   = 0,
    PRI_DEF_TRACE   = 1,
    PRI_DEF_UNEQ    = 2,
    PRI_DEF_PTR     = 3,
    PRI_DEF_ALARM   = 4
  } pri_defect_e;

  localparam int PRI_NUM_DEFECTS = 5;   // Number of defect slots.

endpackage : pri_pkg

// file: pri_code_select.sv
// Purpose: Picks the indication code of the most severe enabled defect.
// Assumes: Defect and code vectors share the same index order.
// Notes:   Purely combinational; the caller registers the result.
// The header is included here too, so its macros do not depend on the
// order in which the files are compiled.
`include "pri_rdi_consts.svh"

module pri_code_select #(
  parameter int N_DEF = 5
) (
  // Defect conditions and their enables.
  input  wire logic [N_DEF-1:0]   active_in,
  // Codes, three bits per slot, slot 0 in the low bits.
  input  wire logic [3*N_DEF-1:0] codes_in,
  // Selected code and hit flag.
  output logic      [2:0]         code_out,
  output logic                    hit_out
);

  // ---------------------------------------------------------------------------
  // Priority chain
  // ---------------------------------------------------------------------------
  // Each stage overrides the one below it, so the highest index wins.
  pri_pkg::pri_code_t chain [0:N_DEF];
  logic               found [0:N_DEF];

  assign chain[0] = `PRI_CODE_NONE;   // No defect sends an all-zero field.
  assign found[0] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < N_DEF; g++) begin : g_stage
      assign chain[g+1] = active_in[g] ? codes_in[3*g +: 3] : chain[g];
      assign found[g+1] = active_in[g] | found[g];
    end
  endgenerate

  assign code_out = chain[N_DEF];
  assign hit_out  = found[N_DEF];

endmodule : pri_code_select

// file: pri_rdi_insert.sv
// Purpose: In automatic mode, fills the remote-defect field of each outbound G1
//          byte from the receive-side defect declarations and the programmed codes.
// Assumes: Defect inputs and the byte stream run on ref_clk_in.
// Notes:   One cycle of latency on the stream and on register reads.
`include "pri_rdi_consts.svh"

module pri_rdi_insert (
  // Clock and reset.
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  // Register port.
  input  wire logic [15:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  // Defects declared by the receive path processor.
  input  wire logic       label_mismatch_in,
  input  wire logic       trace_mismatch_in,
  input  wire logic       unequipped_in,
  input  wire logic       pointer_loss_in,
  input  wire logic       path_alarm_in,
  // Outbound byte stream.
  input  wire logic [7:0] tx_byte_in,
  input  wire logic       tx_valid_in,
  input  wire logic       tx_g1_in,
  output logic      [7:0] tx_byte_out,
  output logic            tx_valid_out,
  output logic            tx_g1_out
);

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  pri_pkg::pri_byte_t lcd_plm;          // Label mismatch control byte.
  pri_pkg::pri_byte_t tim_uneq;         // Trace and unequipped control byte.
  pri_pkg::pri_byte_t lop_ais;          // Pointer-loss and alarm control byte.
  logic [1:0]         insert_source;    // Indication field source select.
  pri_pkg::pri_byte_t next_lcd_plm;
  pri_pkg::pri_byte_t next_tim_uneq;
  pri_pkg::pri_byte_t next_lop_ais;
  logic [1:0]         next_insert_source;
  pri_pkg::pri_byte_t next_rdata;

  // Decode writes and reads. Unmapped reads return zero, unmapped writes
  // are dropped, so a stray access cannot alter the indication.
  always_comb begin
    next_lcd_plm       = lcd_plm;
    next_tim_uneq      = tim_uneq;
    next_lop_ais       = lop_ais;
    next_insert_source = insert_source;
    next_rdata         = reg_rdata_out;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `PRI_ADDR_LCD_PLM:   next_lcd_plm  = reg_wdata_in;
        `PRI_ADDR_TIM_UNEQ:  next_tim_uneq = reg_wdata_in;
        `PRI_ADDR_LOP_AIS:   next_lop_ais  = reg_wdata_in;
        `PRI_ADDR_PATH_CTRL: begin
          next_insert_source = reg_wdata_in[`PRI_SRC_HI:`PRI_SRC_LO];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `PRI_ADDR_LCD_PLM:   next_rdata = lcd_plm;
        `PRI_ADDR_TIM_UNEQ:  next_rdata = tim_uneq;
        `PRI_ADDR_LOP_AIS:   next_rdata = lop_ais;
        `PRI_ADDR_PATH_CTRL: begin
          // Only the source field lives here; other bits read as zero.
          next_rdata = {3'h0, insert_source, 3'h0};
        end
        default:             next_rdata = `PRI_RDATA_UNMAPPED;
      endcase
    end
  end

  // Register the control state and read data.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lcd_plm       <= `PRI_RST_CTRL_BYTE;
      tim_uneq      <= `PRI_RST_CTRL_BYTE;
      lop_ais       <= `PRI_RST_CTRL_BYTE;
      insert_source <= `PRI_RST_SRC;
      reg_rdata_out <= `PRI_RDATA_UNMAPPED;
    end else begin
      lcd_plm       <= next_lcd_plm;
      tim_uneq      <= next_tim_uneq;
      lop_ais       <= next_lop_ais;
      insert_source <= next_insert_source;
      reg_rdata_out <= next_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Defect gating and code selection
  // ---------------------------------------------------------------------------
  logic [pri_pkg::PRI_NUM_DEFECTS-1:0]   defect_active;  // Declared and enabled.
  logic [3*pri_pkg::PRI_NUM_DEFECTS-1:0] code_bank;      // Codes by slot.
  pri_pkg::pri_code_t                    sel_code;       // Winning code.
  logic                                  sel_hit;        // Any slot active.
  logic                                  auto_mode;      // Automatic insertion.

  // A cleared enable masks its defect entirely.
  assign defect_active = {
    path_alarm_in     & lop_ais[`PRI_LO_EN_BIT],
    pointer_loss_in   & lop_ais[`PRI_HI_EN_BIT],
    unequipped_in     & tim_uneq[`PRI_LO_EN_BIT],
    trace_mismatch_in & tim_uneq[`PRI_HI_EN_BIT],
    label_mismatch_in & lcd_plm[`PRI_LO_EN_BIT]
  };

  assign code_bank = {
    lop_ais[`PRI_LO_CODE_HI:`PRI_LO_CODE_LO],
    lop_ais[`PRI_HI_CODE_HI:`PRI_HI_CODE_LO],
    tim_uneq[`PRI_LO_CODE_HI:`PRI_LO_CODE_LO],
    tim_uneq[`PRI_HI_CODE_HI:`PRI_HI_CODE_LO],
    lcd_plm[`PRI_LO_CODE_HI:`PRI_LO_CODE_LO]
  };

  // Severity order alarm, pointer loss, unequipped, trace, label.
  pri_code_select #(
    .N_DEF     (pri_pkg::PRI_NUM_DEFECTS)
  ) u_select (
    .active_in (defect_active),
    .codes_in  (code_bank),
    .code_out  (sel_code),
    .hit_out   (sel_hit)
  );

  assign auto_mode = (insert_source == `PRI_SRC_AUTO);

  // ---------------------------------------------------------------------------
  // Outbound stream
  // ---------------------------------------------------------------------------
  pri_pkg::pri_byte_t next_tx_byte;
  logic               next_tx_valid;
  logic               next_tx_g1;

  // Only the G1 byte in automatic mode is touched; every other byte, and
  // G1 in other modes, passes unchanged so other sources keep control.
  always_comb begin
    next_tx_byte  = tx_byte_in;
    next_tx_valid = tx_valid_in;
    next_tx_g1    = tx_valid_in & tx_g1_in;
    if (tx_valid_in && tx_g1_in && auto_mode) begin
      next_tx_byte[`PRI_G1_FIELD_HI:`PRI_G1_FIELD_LO] = sel_code;
    end
  end

  // Register the stream; data outputs come straight from these flops.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_byte_out  <= 8'h00;
      tx_valid_out <= 1'b0;
      tx_g1_out    <= 1'b0;
    end else begin
      tx_byte_out  <= next_tx_byte;
      tx_valid_out <= next_tx_valid;
      tx_g1_out    <= next_tx_g1;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic g1_auto;   // An automatic G1 byte is being taken this cycle.
  assign g1_auto = tx_valid_in && tx_g1_in && auto_mode;

  label_insert_a: assert property (g1_auto && defect_active == 5'h01
    |=> tx_byte_out[3:1] == $past(lcd_plm[3:1])) else $error("label code not sent");
  uneq_code_a: assert property (g1_auto && defect_active[4:2] == 3'h1
    |=> tx_byte_out[3:1] == $past(tim_uneq[3:1])) else $error("unequipped code wrong");
  uneq_masked_a: assert property (g1_auto && unequipped_in && !tim_uneq[0]
    && defect_active == 5'h00 |=> tx_byte_out[3:1] == 3'h0)
    else $error("masked unequipped altered field");
  // Judged on the outbound side, so every G1 byte that leaves in automatic mode with only unequipped active is checked.
  uneq_each_frame_a: assert property (tx_g1_out && $past(auto_mode)
    && $past(defect_active) == 5'h04 |-> tx_byte_out[3:1] == $past(tim_uneq[3:1]))
    else $error("unequipped code missing on a frame");
  ptr_insert_a: assert property (g1_auto && defect_active[4:3] == 2'h1
    |=> tx_byte_out[3:1] == $past(lop_ais[7:5])) else $error("pointer code not sent");
  ptr_enable_a: assert property (pointer_loss_in && !lop_ais[4]
    |-> !defect_active[3]) else $error("pointer loss not masked");
  alarm_insert_a: assert property (g1_auto && defect_active[4]
    |=> tx_byte_out[3:1] == $past(lop_ais[3:1])) else $error("alarm code not sent");
  alarm_enable_a: assert property (defect_active[4]
    |-> path_alarm_in && lop_ais[0]) else $error("alarm slot active without cause");
  source_gate_a: assert property (tx_valid_in && !auto_mode
    |=> tx_byte_out == $past(tx_byte_in)) else $error("non-automatic byte altered");
  other_bits_a: assert property (tx_valid_in
    |=> {tx_byte_out[7:4], tx_byte_out[0]} == {$past(tx_byte_in[7:4]), $past(tx_byte_in[0])})
    else $error("bits outside indication field altered");
  trace_insert_a: assert property (g1_auto && defect_active[4:1] == 4'h1
    |=> tx_byte_out[3:1] == $past(tim_uneq[7:5])) else $error("trace code not sent");
  idle_zero_a: assert property (g1_auto && !sel_hit
    |=> tx_byte_out[3:1] == 3'h0) else $error("idle field not zero");

  auto_alarm_c:   cover property (g1_auto && defect_active[4] ##1 tx_g1_out);
  auto_idle_c:    cover property (g1_auto && !sel_hit ##1 tx_g1_out);
  two_defects_c:  cover property (g1_auto && defect_active[3] && defect_active[2]);
  reg_readback_c: cover property (reg_wr_in ##2 reg_rd_in);

endmodule : pri_rdi_insert

// file: pri_far_end.sv
// Purpose: Remote path end that records the last G1 byte it receives.
// Assumes: The inserter's stream outputs change just after ref_clk_in rises.
// Notes:   It samples one edge late, so it sees settled values only.
module pri_far_end (
  // Clock and reset.
  input  wire logic          ref_clk_in,
  input  wire logic          rst_n_in,
  // Stream arriving from the inserter.
  input  wire logic [7:0]    rx_byte_in,
  input  wire logic          rx_valid_in,
  input  wire logic          rx_g1_in,
  // Latest G1 byte seen.
  output pri_pkg::pri_byte_t g1_byte_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------------------
  // Capture
  // ---------------------------------------------------------------------------
  // A G1 byte is only taken while valid, as a real receiver would.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      g1_byte_out <= 8'h00;
    end else if (rx_valid_in && rx_g1_in) begin
      g1_byte_out <= rx_byte_in;
    end
  end
endmodule : pri_far_end

// file: tb.sv
// Purpose: Self-checking bench for the remote-defect indication inserter.
// Assumes: Inputs change 1 ns after the rising edge of ref_clk_in.
// Notes:   Every G1 byte sent is 0xA5, so the field under test is bits 3:1.
`include "pri_rdi_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
`define TB_CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end

  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic               ref_clk_in = 1'b0;  // Clock, 40 ns period.
  logic               rst_n_in = 1'b0;    // Reset, low at start.
  logic [15:0]        reg_addr_in = 16'h0000;
  logic               reg_wr_in = 1'b0;
  logic               reg_rd_in = 1'b0;
  pri_pkg::pri_byte_t reg_wdata_in = 8'h00;
  pri_pkg::pri_byte_t reg_rdata_out, tx_byte_out, far_byte, rd;
  logic [4:0]         defs = 5'h00;       // Slot order of pri_defect_e.
  pri_pkg::pri_byte_t tx_byte_in = 8'h00;
  logic               tx_valid_in = 1'b0;
  logic               tx_g1_in = 1'b0;
  logic               tx_valid_out, tx_g1_out;
  int                 err_total = 0;
  int                 n_tests = 0;
  // Codes per slot: label, trace, unequipped, pointer loss, path alarm.
  pri_pkg::pri_code_t codes [5] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h5};

  pri_rdi_insert pri_rdi_insert_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .label_mismatch_in(defs[0]), .trace_mismatch_in(defs[1]), .unequipped_in(defs[2]),
    .pointer_loss_in(defs[3]), .path_alarm_in(defs[4]), .tx_byte_in(tx_byte_in),
    .tx_valid_in(tx_valid_in), .tx_g1_in(tx_g1_in), .tx_byte_out(tx_byte_out),
    .tx_valid_out(tx_valid_out), .tx_g1_out(tx_g1_out));
  pri_far_end pri_far_end_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .rx_byte_in(tx_byte_out), .rx_valid_in(tx_valid_out), .rx_g1_in(tx_g1_out),
    .g1_byte_out(far_byte));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Clock generator; half period is 20 ns.
  initial begin
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  task automatic tick();
    @(posedge ref_clk_in);
    #1;
  endtask : tick
  task automatic reg_wr(input logic [15:0] a, input pri_pkg::pri_byte_t d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    tick();
    reg_wr_in = 1'b0;
    // Let an edge pass so a following call never re-raises the strobe
    // in the same time step in which it was lowered.
    tick();
  endtask : reg_wr
  // Read data is registered at the read edge, so it is settled just after it.
  task automatic reg_rd(input logic [15:0] a, output pri_pkg::pri_byte_t d);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    tick();
    reg_rd_in = 1'b0;
    d = reg_rdata_out;
    tick();
  endtask : reg_rd
  // Expected G1 byte: 0xA5 with the indication field replaced.
  function automatic pri_pkg::pri_byte_t fld(input pri_pkg::pri_code_t c);
    return {4'hA, c, 1'b1};
  endfunction : fld
  // One stream byte; checked at the port and, for a G1 byte, again at the far end.
  task automatic send(input logic g1, input pri_pkg::pri_byte_t exp);
    tx_byte_in = 8'hA5;
    tx_valid_in = 1'b1;
    tx_g1_in = g1;
    tick();
    tx_valid_in = 1'b0;
    `TB_CHK({tx_byte_out, tx_valid_out, tx_g1_out}, {exp, 1'b1, g1})
    tick();
    if (g1) `TB_CHK(far_byte, exp)
  endtask : send

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Reset values, read-back and the unmapped and partial addresses.
  task automatic t_regs();
    reg_rd(`PRI_ADDR_LCD_PLM, rd);
    `TB_CHK(rd, 8'h00)
    reg_rd(`PRI_ADDR_LOP_AIS, rd);
    `TB_CHK(rd, 8'h00)
    reg_wr(`PRI_ADDR_PATH_CTRL, 8'hFF);
    reg_rd(`PRI_ADDR_PATH_CTRL, rd);
    `TB_CHK(rd, 8'h18)
    reg_wr(`PRI_ADDR_PATH_CTRL, 8'h00);
    reg_wr(16'h19CC, 8'hFF);
    reg_rd(16'h19CC, rd);
    `TB_CHK(rd, 8'h00)
  endtask : t_regs
  // Each defect alone, first with its enable clear, then set.
  task automatic t_single();
    reg_wr(`PRI_ADDR_LCD_PLM, 8'h02);
    reg_wr(`PRI_ADDR_TIM_UNEQ, 8'h46);
    reg_wr(`PRI_ADDR_LOP_AIS, 8'hCA);
    for (int i = 0; i < 5; i++) begin
      defs = 5'h01 << i;
      send(1'b1, fld(3'h0));
    end
    reg_wr(`PRI_ADDR_LCD_PLM, 8'h03);
    reg_wr(`PRI_ADDR_TIM_UNEQ, 8'h57);
    reg_wr(`PRI_ADDR_LOP_AIS, 8'hDB);
    reg_rd(`PRI_ADDR_TIM_UNEQ, rd);
    `TB_CHK(rd, 8'h57)
    reg_rd(`PRI_ADDR_LOP_AIS, rd);
    `TB_CHK(rd, 8'hDB)
    for (int i = 0; i < 5; i++) begin
      defs = 5'h01 << i;
      send(1'b1, fld(codes[i]));
    end
    // A later frame with unequipped still declared carries the code again.
    defs = 5'h04;
    send(1'b0, 8'hA5);
    send(1'b1, fld(codes[2]));
  endtask : t_single
  // Several defects at once; the most severe one present wins.
  task automatic t_prio();
    for (int i = 4; i >= 0; i--) begin
      defs = 5'((6'h02 << i) - 6'h01);
      send(1'b1, fld(codes[i]));
    end
    defs = 5'h00;
    send(1'b1, fld(3'h0));
  endtask : t_prio
  // Non-automatic sources pass G1 untouched; plain bytes never change.
  task automatic t_source();
    defs = 5'h1F;
    for (int s = 1; s < 4; s++) begin
      reg_wr(`PRI_ADDR_PATH_CTRL, 8'(s << 3));
      send(1'b1, 8'hA5);
    end
    reg_wr(`PRI_ADDR_PATH_CTRL, 8'h00);
    send(1'b0, 8'hA5);
    send(1'b1, fld(codes[4]));
  endtask : t_source

  // ---------------------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ---------------------------------------------------------------------------
  task automatic results();
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (8) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    t_regs();
    t_single();
    t_prio();
    t_source();
    results();
  end
  // About 92 cycles are needed; the limit leaves a wide margin.
  initial begin
    #100000;
    err_total++;
    results();
  end
endmodule : tb
